/* File: logic/jts_pkg.sv */
/*
 * Package for the jog and torque status block: register map, field
 * positions, reset values and timing counts.
 * Assumes a 25 MHz system clock and a 32-bit classic Wishbone bus.
 */
package jts_pkg;

    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned PORT_W = 8;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_JUDGE = 8'h04;
    localparam logic [7:0] ADDR_LOAD_REF = 8'h08;
    localparam logic [7:0] ADDR_LIMIT_REF = 8'h0c;
    localparam logic [7:0] ADDR_TORQUE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_JOG_CMD = 8'h18;

    // Control register fields.
    localparam int unsigned CTRL_IN_BASE_LSB = 0;
    localparam int unsigned CTRL_OUT_BASE_LSB = 4;
    localparam int unsigned CTRL_TQ_MOVE = 8;
    localparam int unsigned CTRL_PENDANT = 9;
    localparam int unsigned CTRL_PC_BUSY = 10;
    localparam int unsigned CTRL_RUNNING = 11;
    localparam int unsigned CTRL_ERROR = 12;
    localparam int unsigned CTRL_MOTOR_STOP = 13;
    localparam int unsigned CTRL_POS_KNOWN = 14;
    localparam int unsigned CTRL_JOG_DONE = 15;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] JUDGE_RESET = 32'h0000_0014;
    localparam logic [15:0] LOAD_REF_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_REF_RESET = 16'hffff;

    // Judgement time unit is 0.1 s.
    localparam int unsigned JUDGE_UNIT_MS = 100;
    localparam int unsigned JUDGE_UNIT_CYC = CLK_HZ / 1000 * JUDGE_UNIT_MS;

    // Jog input and output group offsets and widths.
    localparam int unsigned JIN_INCH = 4;
    localparam int unsigned JIN_LOW = 5;
    localparam int unsigned JIN_HIGH = 6;
    localparam int unsigned JIN_DIR = 7;
    localparam int unsigned JOUT_READY = 4;
    localparam int unsigned JIN_W = 8;
    localparam int unsigned JOUT_W = 5;

    typedef enum logic [1:0] {
        JTS_SPD_NONE,
        JTS_SPD_INCH,
        JTS_SPD_LOW,
        JTS_SPD_HIGH
    } jts_speed_t;

endpackage

/* File: logic/jts_core.sv */
/*
 * Jog handshake and torque status outputs of one axis controller, with
 * a classic Wishbone register slave.
 * Assumes all inputs are synchronous to clk_i except the discrete jog
 * port, which is resynchronised here; the motion engine reads the jog
 * command register and reports back through the control register.
 */
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
// Functional notes
// - Torque outputs only during torque-limited move.
// - Load output after torque above reference, timed.
// - Load output drops at once when below.
// - Limit output after torque at limit, timed.
// - Limit output drops at once when below.
// - Lock output is stop plus timed limit.
// - Jog outputs five bits from base bit.
// - Jog inputs eight bits from base bit.
// - Bits past port end are ignored.
// - Offsets decode axes, speeds and direction.
// - Request bit n selects station n.
// - Jog chosen axis with chosen class, direction.
// - Refuse requests while jog-ready is low.
// - Inching beats low speed beats high speed.
// - Only one axis jogs at once.
// - Class and direction latched at request edge.
// - Ready drops and flag rises; reverse on release.
// - Soft limits only when position known.
// - Inching uses increment at low speed.
// - Fieldbus jog bits ORed in and mirrored.
`timescale 1ns/1ns
`default_nettype none

module jts_core
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic [15:0] torque_i,
    input wire logic [7:0] jog_port_i,
    input wire logic [7:0] fb_jog_in_i,
    output logic [7:0] jog_port_o,
    output logic [4:0] fb_jog_out_o,
    output logic task_load_o,
    output logic task_limit_o,
    output logic task_lock_o
);

    logic [31:0] ctrl_reg;
    logic [31:0] judge_reg;
    logic [15:0] load_ref_reg;
    logic [15:0] limit_ref_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] jin;
    logic [7:0] jin_prev_reg;
    logic [3:0] axis_reg;
    logic jogging_reg;
    jts_pkg::jts_speed_t speed_reg;
    logic dir_reg;
    logic soft_lim_reg;
    logic [31:0] load_cnt_reg;
    logic [31:0] limit_cnt_reg;
    logic [31:0] judge_cyc;
    logic load_ok;
    logic limit_ok;
    logic tq_move;
    logic ready;
    logic [2:0] in_base;
    logic [2:0] out_base;
    logic [3:0] req_rise;
    logic [4:0] jout;
    jts_pkg::jts_speed_t speed_sel;
    logic wb_hit;

    assign tq_move = ctrl_reg[jts_pkg::CTRL_TQ_MOVE];
    assign in_base = ctrl_reg[jts_pkg::CTRL_IN_BASE_LSB +: 3];
    assign out_base = ctrl_reg[jts_pkg::CTRL_OUT_BASE_LSB +: 3];
    assign judge_cyc = 32'(judge_reg * jts_pkg::JUDGE_UNIT_CYC);
    assign wb_hit = cyc_i && stb_i && !ack_o;

    // Wishbone slave: one wait state, ack for one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= wb_hit;
            dat_o <= 32'h0000_0000;
            if (wb_hit && !we_i)
            begin
                case (adr_i)
                    jts_pkg::ADDR_CTRL: dat_o <= ctrl_reg;
                    jts_pkg::ADDR_JUDGE: dat_o <= judge_reg;
                    jts_pkg::ADDR_LOAD_REF: dat_o <= {16'h0000, load_ref_reg};
                    jts_pkg::ADDR_LIMIT_REF:
                        dat_o <= {16'h0000, limit_ref_reg};
                    jts_pkg::ADDR_TORQUE: dat_o <= {16'h0000, torque_i};
                    jts_pkg::ADDR_STATUS:
                        dat_o <= {24'h000000, task_lock_o, task_limit_o,
                            task_load_o, ready, axis_reg};
                    jts_pkg::ADDR_JOG_CMD:
                        dat_o <= {24'h000000, soft_lim_reg, dir_reg,
                            speed_reg, axis_reg};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration writes with byte enables.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= jts_pkg::CTRL_RESET;
            judge_reg <= jts_pkg::JUDGE_RESET;
            load_ref_reg <= jts_pkg::LOAD_REF_RESET;
            limit_ref_reg <= jts_pkg::LIMIT_REF_RESET;
        end
        else if (wb_hit && we_i)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (sel_i[b])
                begin
                    if (adr_i == jts_pkg::ADDR_CTRL)
                        ctrl_reg[8*b +: 8] <= dat_i[8*b +: 8];
                    if (adr_i == jts_pkg::ADDR_JUDGE)
                        judge_reg[8*b +: 8] <= dat_i[8*b +: 8];
                    if (adr_i == jts_pkg::ADDR_LOAD_REF && b < 2)
                        load_ref_reg[8*b +: 8] <= dat_i[8*b +: 8];
                    if (adr_i == jts_pkg::ADDR_LIMIT_REF && b < 2)
                        limit_ref_reg[8*b +: 8] <= dat_i[8*b +: 8];
                end
            end
        end
    end

    // Two-stage synchroniser on the discrete jog port.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end
        else
        begin
            sync1_reg <= jog_port_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Extract the input group; bits past the port end take the fieldbus bit alone.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_jin
            assign jin[gi] = ((32'(in_base) + gi) < jts_pkg::PORT_W) ?
                (sync2_reg[3'(32'(in_base) + gi)] | fb_jog_in_i[gi]) :
                fb_jog_in_i[gi];
        end
    endgenerate

    // Ready is low while pendant, PC tool, running or error is active.
    assign ready = !jogging_reg && !ctrl_reg[jts_pkg::CTRL_PENDANT] &&
        !ctrl_reg[jts_pkg::CTRL_PC_BUSY] &&
        !ctrl_reg[jts_pkg::CTRL_RUNNING] &&
        !ctrl_reg[jts_pkg::CTRL_ERROR];

    assign req_rise = jin[3:0] & ~jin_prev_reg[3:0];

    always_comb
    begin
        if (jin[jts_pkg::JIN_INCH])
            speed_sel = jts_pkg::JTS_SPD_INCH;
        else if (jin[jts_pkg::JIN_LOW])
            speed_sel = jts_pkg::JTS_SPD_LOW;
        else if (jin[jts_pkg::JIN_HIGH])
            speed_sel = jts_pkg::JTS_SPD_HIGH;
        else
            speed_sel = jts_pkg::JTS_SPD_NONE;
    end

    // Jog handshake: accept one single-axis request edge when ready.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            jin_prev_reg <= 8'h00;
            jogging_reg <= 1'b0;
            axis_reg <= 4'h0;
            speed_reg <= jts_pkg::JTS_SPD_NONE;
            dir_reg <= 1'b0;
            soft_lim_reg <= 1'b0;
        end
        else
        begin
            jin_prev_reg <= jin;
            if (jogging_reg)
            begin
                if (((jin[3:0] & axis_reg) == 4'h0) ||
                    ctrl_reg[jts_pkg::CTRL_JOG_DONE])
                begin
                    jogging_reg <= 1'b0;
                    axis_reg <= 4'h0;
                end
            end
            else if (ready && $onehot(req_rise) &&
                (jin[3:0] == req_rise) &&
                speed_sel != jts_pkg::JTS_SPD_NONE)
            begin
                jogging_reg <= 1'b1;
                axis_reg <= req_rise;
                speed_reg <= speed_sel;
                dir_reg <= jin[jts_pkg::JIN_DIR];
                soft_lim_reg <= ctrl_reg[jts_pkg::CTRL_POS_KNOWN];
            end
        end
    end

    assign jout = {ready, axis_reg};

    // Place the output group at its base bit, dropping overflow bits.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            jog_port_o <= 8'h00;
            fb_jog_out_o <= 5'h00;
        end
        else
        begin
            fb_jog_out_o <= jout;
            for (int p = 0; p < 8; p++)
            begin
                if (p >= 32'(out_base) && p < 32'(out_base) + 5)
                    jog_port_o[p] <= jout[3'(p - 32'(out_base))];
                else
                    jog_port_o[p] <= 1'b0;
            end
        end
    end

    assign load_ok = tq_move && (torque_i > load_ref_reg);
    assign limit_ok = tq_move && (torque_i >= limit_ref_reg);

    // Judgement timers and torque status outputs.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            load_cnt_reg <= 32'h0000_0000;
            limit_cnt_reg <= 32'h0000_0000;
            task_load_o <= 1'b0;
            task_limit_o <= 1'b0;
            task_lock_o <= 1'b0;
        end
        else
        begin
            load_cnt_reg <= !load_ok ? 32'h0000_0000 :
                (load_cnt_reg > judge_cyc ? load_cnt_reg :
                load_cnt_reg + 32'h0000_0001);
            limit_cnt_reg <= !limit_ok ? 32'h0000_0000 :
                (limit_cnt_reg > judge_cyc ? limit_cnt_reg :
                limit_cnt_reg + 32'h0000_0001);
            task_load_o <= load_ok && load_cnt_reg >= judge_cyc;
            task_limit_o <= limit_ok && limit_cnt_reg >= judge_cyc;
            task_lock_o <= limit_ok && limit_cnt_reg >= judge_cyc &&
                ctrl_reg[jts_pkg::CTRL_MOTOR_STOP];
        end
    end

endmodule

`default_nettype wire

/* File: verification/jts_host.sv */
/*
 * Model of the outside controller on the discrete jog pins.
 * Assumes ready_i is the block's jog-ready flag and cmd_i, axis_i are
 * already placed at the input base bit.
 */
`timescale 1ns/1ns
`default_nettype none
module jts_host
#(
    parameter int GAP = 750000
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic ready_i,
    input wire logic [7:0] cmd_i,
    input wire logic [7:0] axis_i,
    output logic [7:0] pins_o
);
    int cnt_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_reg <= 0;
        else if (cnt_reg > 0)
            cnt_reg <= cnt_reg - 1;
        else if (go_i && ready_i)
            cnt_reg <= GAP + 40;
    end
    // Class and direction first, one axis a cycle later, then a gap.
    assign pins_o = (cnt_reg > GAP) ?
        (cmd_i | ((cnt_reg < GAP + 40) ? axis_i : 8'h00)) : 8'h00;
endmodule
`default_nettype wire

/* File: verification/jts_core_chk.sv */
/*
 * Port checker for jts_core.
 * Assumes it is bound to every jts_core instance.
 */
`timescale 1ns/1ns
`default_nettype none
module jts_core_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [7:0] jog_port_i,
    input wire logic [7:0] fb_jog_in_i,
    input wire logic [7:0] jog_port_o,
    input wire logic [4:0] fb_jog_out_o,
    input wire logic task_load_o,
    input wire logic task_limit_o,
    input wire logic task_lock_o
);
    logic [15:0] ctl_reg;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctl_reg <= 16'h0000;
        else if (cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h00)
            ctl_reg <= dat_i[15:0];
    end
    sequence s_off;
        !ctl_reg[8] [*4];
    endsequence
    sequence s_block;
        (ctl_reg[12:9] != 4'h0) [*4];
    endsequence
    AST_TQ_GATE: assert property (s_off |-> !task_load_o &&
        !task_limit_o && !task_lock_o) else $error("torque out idle");
    AST_LOCK_LIMIT: assert property (task_lock_o |-> task_limit_o ||
        $past(task_limit_o)) else $error("lock without limit");
    AST_ONE_AXIS: assert property ($countones(fb_jog_out_o[3:0]) <= 1)
        else $error("two axes jogging");
    AST_READY_IDLE: assert property (fb_jog_out_o[4] |->
        fb_jog_out_o[3:0] == 4'h0) else $error("ready while jogging");
    AST_GRANT: assert property ($rose(|fb_jog_out_o[3:0]) |->
        $past(fb_jog_out_o[4])) else $error("grant without ready");
    AST_READY_BLOCK: assert property (s_block |-> !fb_jog_out_o[4])
        else $error("ready while blocked");
    AST_MIRROR: assert property ($stable(ctl_reg[6:4]) [*4] |->
        jog_port_o == 8'({3'h0, fb_jog_out_o} << ctl_reg[6:4]))
        else $error("port differs from copy");
    AST_HOLD: assert property (fb_jog_out_o[3:0] != 4'h0 |->
        ($past(fb_jog_in_i[3:0], 2) & fb_jog_out_o[3:0]) != 4'h0 ||
        $past(|jog_port_i, 4)) else $error("jog without request");
endmodule
bind jts_core jts_core_chk i_jts_core_chk (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .jog_port_i(jog_port_i),
    .fb_jog_in_i(fb_jog_in_i), .jog_port_o(jog_port_o),
    .fb_jog_out_o(fb_jog_out_o), .task_load_o(task_load_o),
    .task_limit_o(task_limit_o), .task_lock_o(task_lock_o));
`default_nettype wire

/* File: verification/jts_core_bench.sv */
/*
 * Self-checking bench for jts_core with the jog host model.
 * Assumes jts_pkg, jts_host and the checker are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module jts_core_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0;
    logic stb_i = 1'b0, go = 1'b0, probe = 1'b0;
    logic [7:0] adr_i = 8'h00, fb_jog_in_i = 8'h00, g;
    logic [31:0] dat_i = 32'h0, dat_o, rnd;
    logic [15:0] torque_i = 16'h0;
    logic [3:0] sel_i = 4'h0;
    logic [7:0] jog_port_i, jog_port_o;
    logic [4:0] fb_jog_out_o;
    logic [1:0] sp;
    logic ack_o, task_load_o, task_limit_o, task_lock_o;
    logic [31:0] exp_q[$];
    logic [15:0] tt[6] = '{16'h150, 16'h200, 16'h200, 16'h100, 16'h1ff,
        16'h300};
    logic [15:0] tc[6] = '{16'h100, 16'h100, 16'h2100, 16'h2100,
        16'h2100, 16'h2000};
    logic [2:0] te[6] = '{3'h1, 3'h3, 3'h7, 3'h0, 3'h1, 3'h0};
    int fail_count = 0, checked = 0, cycles = 0;
    jts_core i_jts_core (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .torque_i(torque_i),
        .jog_port_i(jog_port_i), .fb_jog_in_i(fb_jog_in_i),
        .jog_port_o(jog_port_o), .fb_jog_out_o(fb_jog_out_o),
        .task_load_o(task_load_o), .task_limit_o(task_limit_o),
        .task_lock_o(task_lock_o));
    jts_host #(.GAP(64)) i_jts_host (.clk_i(clk_i), .rst_i(rst_i),
        .go_i(go), .ready_i(fb_jog_out_o[4]), .cmd_i(8'hc0),
        .axis_i(8'h08), .pins_o(jog_port_i));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic report_and_stop();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic see(input logic [4:0] f, input logic [2:0] b,
        input logic [2:0] t);
        exp_q.push_back({16'h0, f, 8'({3'h0, f} << b), t});
        @(posedge clk_i) probe <= 1'b1;
        @(posedge clk_i) probe <= 1'b0;
    endtask
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            report_and_stop();
        end
        if (ack_o === 1'b1 && we_i === 1'b0)
            chk(dat_o, exp_q.pop_front());
        if (probe === 1'b1)
            chk({16'h0, fb_jog_out_o, jog_port_o, task_lock_o,
                task_limit_o, task_load_o}, exp_q.pop_front());
    end
    initial
    begin
        rnd = 32'd33;
        wt(16);
        rst_i <= 1'b0;
        wt(3);
        see(5'h10, 3'h0, 3'h0);
        bus(1'b1, 8'h1c, 32'hffffffff);
        rd(8'h1c, 32'h0);
        rd(jts_pkg::ADDR_JUDGE, jts_pkg::JUDGE_RESET);
        rd(jts_pkg::ADDR_LIMIT_REF, 32'hffff);
        for (int k = 0; k < 4; k++)
        begin
            rnd = xs(rnd);
            g = {rnd[3], (rnd[2:0] == 3'h0) ? 3'h2 : rnd[2:0], 4'h0};
            sp = g[4] ? 2'h1 : (g[5] ? 2'h2 : 2'h3);
            @(posedge clk_i) fb_jog_in_i <= g;
            @(posedge clk_i) fb_jog_in_i <= g | (8'h01 << k);
            wt(3);
            fb_jog_in_i <= (g ^ 8'hf0) | (8'h01 << k);
            see({1'b0, 4'h1 << k}, 3'h0, 3'h0);
            rd(jts_pkg::ADDR_JOG_CMD, {24'h0, 1'b0, g[7], sp, 4'h1 << k});
            fb_jog_in_i <= 8'h00;
            wt(64);
            see(5'h10, 3'h0, 3'h0);
        end
        for (int i = 9; i < 13; i++)
        begin
            bus(1'b1, jts_pkg::ADDR_CTRL, 32'h1 << i);
            fb_jog_in_i <= 8'h21;
            wt(4);
            see(5'h00, 3'h0, 3'h0);
        end
        bus(1'b1, jts_pkg::ADDR_CTRL, 32'h0);
        wt(4);
        see(5'h10, 3'h0, 3'h0);
        @(posedge clk_i) fb_jog_in_i <= 8'h00;
        wt(3);
        fb_jog_in_i <= 8'h23;
        wt(4);
        see(5'h10, 3'h0, 3'h0);
        fb_jog_in_i <= 8'h00;
        bus(1'b1, jts_pkg::ADDR_CTRL, 32'h4051);
        @(posedge clk_i) go <= 1'b1;
        @(posedge clk_i) go <= 1'b0;
        wt(10);
        see(5'h04, 3'h5, 3'h0);
        rd(jts_pkg::ADDR_JOG_CMD, 32'ha4);
        wt(110);
        see(5'h10, 3'h5, 3'h0);
        bus(1'b1, jts_pkg::ADDR_JUDGE, 32'h0);
        bus(1'b1, jts_pkg::ADDR_LOAD_REF, 32'h100);
        bus(1'b1, jts_pkg::ADDR_LIMIT_REF, 32'h200);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, jts_pkg::ADDR_CTRL, {16'h0, tc[i]});
            torque_i <= tt[i];
            wt(4);
            see(5'h10, 3'h0, te[i]);
        end
        rd(jts_pkg::ADDR_TORQUE, {16'h0, tt[5]});
        report_and_stop();
    end
endmodule
`default_nettype wire
